/* shared/psr_pkg.sv */
// Constants shared by the power sequencing and status register block.
// Assumes one 250 MHz clock and a command-level access port in front of the serial bus.
package psr_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] PSR_CMD_PGOOD_THRESHOLD = 8'h5e; // Power-good threshold
    localparam logic [7:0] PSR_CMD_TURN_ON_DELAY = 8'h60; // Delay before output rise
    localparam logic [7:0] PSR_CMD_TURN_ON_RAMP = 8'h61; // Output rise time
    localparam logic [7:0] PSR_CMD_TURN_OFF_DELAY = 8'h64; // Delay before output fall
    localparam logic [7:0] PSR_CMD_TURN_OFF_RAMP = 8'h65; // Output fall time
    localparam logic [7:0] PSR_CMD_SUMMARY_BYTE = 8'h78; // One-byte fault summary
    localparam logic [7:0] PSR_CMD_SUMMARY_WORD = 8'h79; // Two-byte fault summary

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] PSR_TIMER_RESET = 16'hca80; // 5 ms in linear_11_format
    localparam logic [7:0] PSR_SUMMARY_BYTE_RESET = 8'h00;
    localparam logic [15:0] PSR_SUMMARY_WORD_RESET = 16'h0000;
    localparam int PSR_PGOOD_NUM = 9; // Threshold default is setpoint * 9 / 10
    localparam int PSR_PGOOD_DEN = 10;

    // ------------------------------------------------------------------
    // Summary bit positions
    // ------------------------------------------------------------------
    localparam int PSR_BIT_BUSY = 7;
    localparam int PSR_BIT_OFF = 6;
    localparam int PSR_BIT_OUT_OV = 5;
    localparam int PSR_BIT_OUT_OC = 4;
    localparam int PSR_BIT_IN_UV = 3;
    localparam int PSR_BIT_TEMP = 2;
    localparam int PSR_BIT_CML = 1;
    localparam int PSR_BIT_CATCH_ALL = 0;
    localparam int PSR_BIT_VOUT = 15;
    localparam int PSR_BIT_OUTPUT_CURRENT_POWER_FLAG = 14;
    localparam int PSR_BIT_INPUT = 13;
    localparam int PSR_BIT_VENDOR = 12;
    localparam int PSR_BIT_PGOOD_N = 11;
    localparam int PSR_BIT_FANS = 10;
    localparam int PSR_BIT_OTHER = 9;
    localparam int PSR_BIT_UNKNOWN = 8;
    // Positions inside the detailed status bytes
    localparam int PSR_DET_OUT_OV = 7; // Output overvoltage fault in output voltage status
    localparam int PSR_DET_OUT_OC = 7; // Output overcurrent fault in output current status
    localparam int PSR_DET_IN_UV = 4; // Input undervoltage fault in input status

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int PSR_CLK_MHZ = 250; // Core clock rate
    localparam int PSR_TICK_US = 1; // Timer resolution in microseconds
    localparam int PSR_CYCLES_PER_TICK = PSR_CLK_MHZ * PSR_TICK_US;
    localparam int PSR_ON_DELAY_MAX_MS = 500;
    localparam int PSR_ON_RAMP_MAX_MS = 200;
    localparam int PSR_OFF_DELAY_MAX_MS = 256;
    localparam int PSR_OFF_RAMP_MAX_MS = 200;
    localparam int PSR_US_PER_MS = 1000;
    localparam int PSR_TIME_W = 20; // Wide enough for 500000 us

    // Sequencer states
    typedef enum logic [2:0] {
        PSR_ST_OFF = 3'b000,
        PSR_ST_ON_DELAY = 3'b001,
        PSR_ST_RISE = 3'b010,
        PSR_ST_ON = 3'b011,
        PSR_ST_OFF_DELAY = 3'b100,
        PSR_ST_FALL = 3'b101
    } psr_state_t;

endpackage

/* hdl/psr_l11_to_time.sv */
// Converts a linear_11_format millisecond value into a count of timer ticks.
// Assumes the value is held stable by the register bank; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module psr_l11_to_time #(
    parameter int MAX_MS = 500
) (
    input wire logic [15:0] i_l11,
    output logic [psr_pkg::PSR_TIME_W-1:0] o_ticks
);
    import psr_pkg::*;

    // ------------------------------------------------------------------
    // Field split and scaling
    // ------------------------------------------------------------------
    localparam logic [31:0] MAX_TICKS = 32'(MAX_MS * PSR_US_PER_MS / PSR_TICK_US);
    localparam logic [31:0] US_PER_MS = 32'(PSR_US_PER_MS / PSR_TICK_US);

    wire logic [4:0] exp_raw = i_l11[15:11]; // Signed exponent
    wire logic man_neg = i_l11[10]; // Negative mantissa means no time at all
    wire logic [4:0] shift_amt = exp_raw[4] ? 5'(~exp_raw + 5'h01) : exp_raw;
    wire logic [31:0] product = {22'h0, i_l11[9:0]} * US_PER_MS;
    // Left shifts past 11 places overflow any legal range, so they saturate
    wire logic too_big = !exp_raw[4] && (shift_amt > 5'h0b);
    wire logic [31:0] shifted = exp_raw[4] ? (product >> shift_amt) : (product << shift_amt);
    wire logic [31:0] clamped = (too_big || shifted > MAX_TICKS) ? MAX_TICKS : shifted;

    // Out-of-range requests clamp to the top of the documented span
    assign o_ticks = man_neg ? '0 : clamped[psr_pkg::PSR_TIME_W-1:0];

endmodule
`default_nettype wire

/* hdl/psr_power_sequence_status_regs.sv */
// Power sequencing timers, power-good hysteresis and fault summary registers.
// Assumes a serial-bus front end that presents decoded commands one per cycle,
// and detailed status bytes that are kept by other blocks.
`timescale 1ns/1ps
`default_nettype none

module psr_power_sequence_status_regs (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_cmd_code,
    input wire logic i_wr_en,
    input wire logic [15:0] i_wr_data,
    input wire logic i_rd_en,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_cmd_error,
    input wire logic [15:0] i_output_setpoint,
    input wire logic [15:0] i_vout_meas,
    input wire logic [15:0] i_output_undervolt_limit,
    input wire logic i_enable,
    input wire logic [7:0] i_status_vout,
    input wire logic [7:0] i_status_iout,
    input wire logic [7:0] i_status_input,
    input wire logic [7:0] i_status_temp,
    input wire logic [7:0] i_status_cml,
    input wire logic [7:0] i_status_vendor,
    input wire logic [7:0] i_status_other,
    input wire logic i_fan_flag,
    input wire logic i_busy_flag,
    input wire logic i_unknown_flag,
    output logic o_power_good,
    output logic o_ramp_up,
    output logic o_ramp_down,
    output logic o_output_on,
    output logic o_host_alert
);
    import psr_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0] timer_reg [4]; // Delay and ramp settings, indexed
    logic [15:0] pgood_threshold_reg; // Power-good on level
    logic strap_loaded_reg; // Threshold default taken after reset
    logic [15:0] summary_word_reg; // Low byte doubles as the summary byte
    logic pgood_reg;
    psr_state_t state_reg, state_next;
    logic [PSR_TIME_W-1:0] count_reg, count_next;
    logic [7:0] div_reg; // Tick divider
    logic [15:0] rd_data_reg;
    logic rd_valid_reg, cmd_error_reg, alert_reg;
    logic ramp_up_reg, ramp_down_reg, output_on_reg; // Phase outputs, registered
    logic [PSR_TIME_W-1:0] dur [4]; // Durations in ticks

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    wire logic hit_pgood = (i_cmd_code == PSR_CMD_PGOOD_THRESHOLD);
    wire logic hit_byte = (i_cmd_code == PSR_CMD_SUMMARY_BYTE);
    wire logic hit_word = (i_cmd_code == PSR_CMD_SUMMARY_WORD);
    wire logic [3:0] hit_timer = {i_cmd_code == PSR_CMD_TURN_OFF_RAMP,
                                  i_cmd_code == PSR_CMD_TURN_OFF_DELAY,
                                  i_cmd_code == PSR_CMD_TURN_ON_RAMP,
                                  i_cmd_code == PSR_CMD_TURN_ON_DELAY};
    wire logic hit_rw = hit_pgood || (|hit_timer);
    // Writes to the summaries are refused; they are read-only
    wire logic bad_cmd = (i_wr_en && !hit_rw) || (i_rd_en && !hit_rw && !hit_byte && !hit_word);
    wire logic [15:0] timer_rd = hit_timer[0] ? timer_reg[0] :
                                 hit_timer[1] ? timer_reg[1] :
                                 hit_timer[2] ? timer_reg[2] : timer_reg[3];
    // The byte view is the same flops as the word's low byte
    wire logic [15:0] rd_mux = hit_pgood ? pgood_threshold_reg :
                               hit_word ? summary_word_reg :
                               hit_byte ? {8'h00, summary_word_reg[7:0]} :
                               (|hit_timer) ? timer_rd : 16'h0000;

    // ------------------------------------------------------------------
    // Timer registers and duration decode
    // ------------------------------------------------------------------
    localparam int MAX_MS [4] = '{PSR_ON_DELAY_MAX_MS, PSR_ON_RAMP_MAX_MS,
                                  PSR_OFF_DELAY_MAX_MS, PSR_OFF_RAMP_MAX_MS};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_timer
            // Each setting is host writable and converted straight to ticks
            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    timer_reg[gi] <= PSR_TIMER_RESET;
                end else if (i_wr_en && hit_timer[gi]) begin
                    timer_reg[gi] <= i_wr_data;
                end
            end
            psr_l11_to_time #(.MAX_MS(MAX_MS[gi])) u_conv (
                .i_l11(timer_reg[gi]),
                .o_ticks(dur[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Power-good threshold
    // ------------------------------------------------------------------
    // The strap default is worked out once, one edge after reset release,
    // because an async reset may only load a constant
    wire logic [31:0] strap_scaled = ({16'h0, i_output_setpoint} * 32'(PSR_PGOOD_NUM))
                                     / 32'(PSR_PGOOD_DEN);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pgood_threshold_reg <= 16'h0000;
            strap_loaded_reg <= 1'b0;
        end else if (!strap_loaded_reg) begin
            pgood_threshold_reg <= strap_scaled[15:0];
            strap_loaded_reg <= 1'b1;
        end else if (i_wr_en && hit_pgood) begin
            pgood_threshold_reg <= i_wr_data;
        end
    end

    // Hysteresis: on above threshold, off below undervolt limit, else hold
    wire logic pgood_next = (i_vout_meas > pgood_threshold_reg) ? 1'b1 :
                            (i_vout_meas < i_output_undervolt_limit) ? 1'b0 : pgood_reg;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pgood_reg <= 1'b0;
        end else if (strap_loaded_reg) begin
            pgood_reg <= pgood_next;
        end
    end

    // ------------------------------------------------------------------
    // Tick divider and sequencer
    // ------------------------------------------------------------------
    localparam logic [7:0] DIV_LAST = 8'(PSR_CYCLES_PER_TICK - 1);
    wire logic tick = (div_reg == DIV_LAST);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
        end
    end

    wire logic count_done = (count_reg == '0);
    wire logic [PSR_TIME_W-1:0] count_dec = tick ? count_reg - 1'b1 : count_reg;

    // Durations are sampled at phase entry, so a write mid-phase takes
    // effect at the next entry to the phase that it sets
    always_comb begin
        state_next = state_reg;
        count_next = count_dec;
        unique case (state_reg)
            PSR_ST_OFF: begin
                count_next = '0;
                if (i_enable) begin
                    state_next = PSR_ST_ON_DELAY;
                    count_next = dur[0];
                end
            end
            PSR_ST_ON_DELAY: begin
                if (!i_enable) begin
                    state_next = PSR_ST_OFF; // Output never started
                    count_next = '0;
                end else if (count_done) begin
                    state_next = PSR_ST_RISE;
                    count_next = dur[1];
                end
            end
            PSR_ST_RISE, PSR_ST_ON: begin
                if (!i_enable) begin
                    state_next = PSR_ST_OFF_DELAY;
                    count_next = dur[2];
                end else if (state_reg == PSR_ST_RISE && count_done) begin
                    state_next = PSR_ST_ON;
                    count_next = '0;
                end else if (state_reg == PSR_ST_ON) begin
                    count_next = '0;
                end
            end
            PSR_ST_OFF_DELAY: begin
                if (count_done) begin
                    state_next = PSR_ST_FALL;
                    count_next = dur[3];
                end
            end
            PSR_ST_FALL: begin
                if (count_done) begin
                    state_next = PSR_ST_OFF;
                    count_next = '0;
                end
            end
            default: begin
                state_next = PSR_ST_OFF;
                count_next = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= PSR_ST_OFF;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------------
    // Fault summary
    // ------------------------------------------------------------------
    wire logic powered = (state_next == PSR_ST_RISE) || (state_next == PSR_ST_ON) ||
                         (state_next == PSR_ST_OFF_DELAY) || (state_next == PSR_ST_FALL);
    wire logic [7:0] sum_low;
    wire logic [7:0] sum_high;
    assign sum_low[PSR_BIT_BUSY] = i_busy_flag;
    assign sum_low[PSR_BIT_OFF] = !powered;
    assign sum_low[PSR_BIT_OUT_OV] = i_status_vout[PSR_DET_OUT_OV];
    assign sum_low[PSR_BIT_OUT_OC] = i_status_iout[PSR_DET_OUT_OC];
    assign sum_low[PSR_BIT_IN_UV] = i_status_input[PSR_DET_IN_UV];
    assign sum_low[PSR_BIT_TEMP] = |i_status_temp;
    assign sum_low[PSR_BIT_CML] = |i_status_cml;
    // Everything not shown in bits 7:1 except the power-good negated bit, input warnings among them
    assign sum_low[PSR_BIT_CATCH_ALL] = (|i_status_vout[6:0]) || (|i_status_iout[6:0]) ||
                                        i_status_input[7] || (|i_status_input[6:5]) ||
                                        (|i_status_input[3:0]) || (|i_status_vendor) ||
                                        i_fan_flag || (|i_status_other) || i_unknown_flag;
    assign sum_high[PSR_BIT_VOUT - 8] = |i_status_vout;
    assign sum_high[PSR_BIT_OUTPUT_CURRENT_POWER_FLAG - 8] = |i_status_iout;
    assign sum_high[PSR_BIT_INPUT - 8] = |i_status_input;
    assign sum_high[PSR_BIT_VENDOR - 8] = |i_status_vendor;
    assign sum_high[PSR_BIT_PGOOD_N - 8] = !pgood_next;
    assign sum_high[PSR_BIT_FANS - 8] = i_fan_flag;
    assign sum_high[PSR_BIT_OTHER - 8] = |i_status_other;
    assign sum_high[PSR_BIT_UNKNOWN - 8] = i_unknown_flag;
    // Alert for real events, not for the plain off or not-good states
    wire logic alert_next = (|sum_low[PSR_BIT_OUT_OV:0]) || sum_low[PSR_BIT_BUSY] ||
                            (|sum_high[7:4]) || (|sum_high[2:0]);

    // Summaries are live views of the detailed flags; no host clear exists
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            summary_word_reg <= PSR_SUMMARY_WORD_RESET;
            alert_reg <= 1'b0;
        end else begin
            summary_word_reg <= {sum_high, sum_low};
            alert_reg <= alert_next;
        end
    end

    // Phase outputs follow the next state so they line up with state_reg
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ramp_up_reg <= 1'b0;
            ramp_down_reg <= 1'b0;
            output_on_reg <= 1'b0;
        end else begin
            ramp_up_reg <= (state_next == PSR_ST_RISE);
            ramp_down_reg <= (state_next == PSR_ST_FALL);
            output_on_reg <= powered;
        end
    end

    // ------------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
            cmd_error_reg <= 1'b0;
        end else begin
            rd_valid_reg <= i_rd_en && !bad_cmd;
            cmd_error_reg <= bad_cmd;
            if (i_rd_en) begin
                rd_data_reg <= bad_cmd ? 16'h0000 : rd_mux;
            end
        end
    end

    assign o_rd_data = rd_data_reg;
    assign o_rd_valid = rd_valid_reg;
    assign o_cmd_error = cmd_error_reg;
    assign o_power_good = pgood_reg;
    assign o_ramp_up = ramp_up_reg;
    assign o_ramp_down = ramp_down_reg;
    assign o_output_on = output_on_reg;
    assign o_host_alert = alert_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    pgood_set_a: assert property (strap_loaded_reg && i_vout_meas > pgood_threshold_reg
        |=> o_power_good) else $error("power good not set above threshold");
    pgood_clear_a: assert property (strap_loaded_reg && i_vout_meas <= pgood_threshold_reg
        && i_vout_meas < i_output_undervolt_limit |=> !o_power_good)
        else $error("power good not cleared below limit");
    thr_write_a: assert property (strap_loaded_reg && i_wr_en && hit_pgood
        |=> pgood_threshold_reg == $past(i_wr_data)) else $error("threshold write lost");
    on_delay_a: assert property (state_reg == PSR_ST_OFF && i_enable
        |=> state_reg == PSR_ST_ON_DELAY && count_reg == $past(dur[0]))
        else $error("turn-on delay not loaded");
    rise_start_a: assert property (state_reg == PSR_ST_ON_DELAY && i_enable && count_done
        |=> o_ramp_up) else $error("ramp did not start after delay");
    off_delay_a: assert property ((state_reg == PSR_ST_ON || state_reg == PSR_ST_RISE)
        && !i_enable |=> state_reg == PSR_ST_OFF_DELAY) else $error("turn-off delay skipped");
    fall_start_a: assert property (state_reg == PSR_ST_OFF_DELAY && count_done
        |=> o_ramp_down ##0 count_reg == $past(dur[3])) else $error("fall not started");
    busy_bit_a: assert property (i_busy_flag |=> summary_word_reg[PSR_BIT_BUSY])
        else $error("busy bit missing");
    off_bit_a: assert property (state_reg == PSR_ST_OFF && !i_enable
        |=> summary_word_reg[PSR_BIT_OFF]) else $error("off bit clear while unpowered");
    ov_bit_a: assert property (i_status_vout[PSR_DET_OUT_OV]
        |=> summary_word_reg[PSR_BIT_OUT_OV] && summary_word_reg[PSR_BIT_VOUT])
        else $error("overvolt summary missing");
    cml_bit_a: assert property (|i_status_cml |=> summary_word_reg[PSR_BIT_CML])
        else $error("comm fault summary missing");
    in_warn_a: assert property (|i_status_input[6:5] |=> summary_word_reg[PSR_BIT_CATCH_ALL]
        && summary_word_reg[PSR_BIT_INPUT] && o_host_alert) else $error("input warning lost");
    byte_same_a: assert property (i_rd_en && hit_byte |=> o_rd_data[7:0] ==
        $past(summary_word_reg[7:0]) && o_rd_data[15:8] == 8'h00)
        else $error("summary byte differs from word");
    ro_write_a: assert property (i_wr_en && (hit_byte || hit_word) |=> o_cmd_error)
        else $error("write to summary not refused");
    pgood_n_a: assert property (strap_loaded_reg ##1 !o_power_good
        |-> summary_word_reg[PSR_BIT_PGOOD_N]) else $error("power good negated bit missing");

    full_on_c: cover property (o_ramp_up ##[1:1000] o_output_on && !o_ramp_up);
    full_off_c: cover property (o_ramp_down ##[1:1000] !o_output_on);
    pgood_c: cover property (!o_power_good ##1 o_power_good);
    alert_c: cover property (!o_host_alert ##1 o_host_alert);

endmodule
`default_nettype wire

/* tb/psr_host_model.sv */
// Host model that drives the decoded command port of the status block.
// Assumes the answer is registered at the taking edge and settled 1 ns after it.
`timescale 1ns/1ps
`default_nettype none
module psr_host_model (
    input wire logic i_clk,
    output logic [7:0] o_cmd = 8'h00,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [15:0] o_data = 16'h0000,
    input wire logic [15:0] i_rd_data,
    input wire logic i_rd_valid,
    input wire logic i_err
);
    // One transfer: strobe held until the taking edge, answer sampled after it
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
        @(posedge i_clk);
        o_cmd <= c;
        o_data <= d;
        o_wr <= w;
        o_rd <= !w;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        #1;
        q = i_rd_data;
        ok = (w | i_rd_valid) & !i_err;
    endtask
endmodule
`default_nettype wire

/* tb/psr_power_sequence_status_regs_tb.sv */
// Bench for the sequencing timers and fault summaries.
// Assumes the host model in front of the command port.
`timescale 1ns/1ps
`default_nettype none
module psr_power_sequence_status_regs_tb;
    import psr_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic en = 1'b0;
    logic [58:0] flt = '0; // Detailed flags, one slice per source
    logic [15:0] vout = 16'h0000;
    logic [15:0] q, wd, rdd;
    logic [7:0] cmd;
    logic wr, rd, rv, er, pg, up, dn, on, al, ok;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    initial forever #2 i_clk = ~i_clk;
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            give_verdict();
        end
    end
    psr_power_sequence_status_regs psr_power_sequence_status_regs_i (.i_clk(i_clk),
        .i_reset(i_reset), .i_cmd_code(cmd), .i_wr_en(wr), .i_wr_data(wd), .i_rd_en(rd),
        .o_rd_data(rdd), .o_rd_valid(rv), .o_cmd_error(er), .i_output_setpoint(16'h1000),
        .i_vout_meas(vout), .i_output_undervolt_limit(16'h0c00), .i_enable(en),
        .i_status_vout(flt[7:0]), .i_status_iout(flt[15:8]), .i_status_input(flt[23:16]),
        .i_status_temp(flt[31:24]), .i_status_cml(flt[39:32]), .i_status_vendor(flt[47:40]),
        .i_status_other(flt[55:48]), .i_fan_flag(flt[56]), .i_busy_flag(flt[57]),
        .i_unknown_flag(flt[58]), .o_power_good(pg), .o_ramp_up(up), .o_ramp_down(dn),
        .o_output_on(on), .o_host_alert(al));
    psr_host_model psr_host_model_i (.i_clk(i_clk), .o_cmd(cmd), .o_wr(wr), .o_rd(rd),
        .o_data(wd), .i_rd_data(rdd), .i_rd_valid(rv), .i_err(er));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp, input logic okx);
        psr_host_model_i.xfer(1'b0, c, 16'h0000, q, ok);
        chk(q, exp);
        chk({15'h0, ok}, {15'h0, okx});
    endtask
    // Bounded wait for a level; settled sampling one ns past the edge
    task automatic wait_for(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 5000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask
    task automatic t_reset();
        rd_chk(8'h60, PSR_TIMER_RESET, 1'b1);
        rd_chk(8'h61, PSR_TIMER_RESET, 1'b1);
        rd_chk(8'h64, PSR_TIMER_RESET, 1'b1);
        rd_chk(8'h65, PSR_TIMER_RESET, 1'b1);
        rd_chk(8'h5e, 16'h0e66, 1'b1);
        rd_chk(8'h79, 16'h0840, 1'b1);
        chk({15'h0, al}, 16'h0000);
        psr_host_model_i.xfer(1'b1, 8'h79, 16'hffff, q, ok);
        chk({15'h0, ok}, 16'h0000);
        rd_chk(8'h79, 16'h0840, 1'b1);
        rd_chk(8'h00, 16'h0000, 1'b0);
        psr_host_model_i.xfer(1'b1, 8'h5e, 16'h0d00, q, ok);
        rd_chk(8'h5e, 16'h0d00, 1'b1);
        $display("t_reset done");
    endtask
    // One detailed flag at a time, against the expected word
    task automatic t_summary();
        int pos [12] = '{7, 6, 15, 20, 21, 24, 32, 40, 48, 56, 57, 58};
        logic [15:0] exp [12] = '{16'h8860, 16'h8841, 16'h4850, 16'h2848, 16'h2841,
            16'h0844, 16'h0842, 16'h1841, 16'h0a41, 16'h0c41, 16'h08c0, 16'h0941};
        foreach (pos[k]) begin
            @(posedge i_clk) flt <= 59'h1 << pos[k];
            rd_chk(8'h79, exp[k], 1'b1);
            rd_chk(8'h78, {8'h00, exp[k][7:0]}, 1'b1);
            chk({15'h0, al}, 16'h0001);
        end
        @(posedge i_clk) flt <= '0;
        $display("t_summary done");
    endtask
    task automatic t_sequence();
        logic [7:0] c [4] = '{8'h60, 8'h61, 8'h64, 8'h65};
        int n;
        foreach (c[k]) psr_host_model_i.xfer(1'b1, c[k], 16'hc801, q, ok);
        @(posedge i_clk) en <= 1'b1;
        wait_for(up, 1'b1, n);
        chk({15'h0, n > 250 && n < 5000}, 16'h0001);
        chk({15'h0, on}, 16'h0001);
        rd_chk(8'h79, 16'h0800, 1'b1);
        wait_for(up, 1'b0, n);
        chk({15'h0, n > 250 && n < 5000}, 16'h0001);
        @(posedge i_clk) vout <= 16'h0d80;
        rd_chk(8'h79, 16'h0000, 1'b1);
        chk({15'h0, pg}, 16'h0001);
        @(posedge i_clk) vout <= 16'h0c80;
        rd_chk(8'h79, 16'h0000, 1'b1);
        @(posedge i_clk) vout <= 16'h0b00;
        rd_chk(8'h79, 16'h0800, 1'b1);
        chk({15'h0, pg}, 16'h0000);
        @(posedge i_clk) en <= 1'b0;
        wait_for(dn, 1'b1, n);
        chk({15'h0, n > 250 && n < 5000}, 16'h0001);
        wait_for(dn, 1'b0, n);
        chk({15'h0, n > 250 && n < 5000}, 16'h0001);
        chk({15'h0, on}, 16'h0000);
        $display("t_sequence done");
    endtask
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        t_reset();
        t_summary();
        t_sequence();
        give_verdict();
    end
endmodule
`default_nettype wire
